/* File: verilog/fieldbus_image_pkg.sv */
// shared constants and carrier types for the fieldbus process image block
package fieldbus_image_pkg;
   // apb byte addresses
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_SLOPE     = 8'h08;
   localparam logic [7:0] ADDR_EMIS      = 8'h0c;
   localparam logic [7:0] ADDR_TRANS     = 8'h10;
   localparam logic [7:0] ADDR_AVG       = 8'h14;
   localparam logic [7:0] ADDR_PEAK      = 8'h18;
   localparam logic [7:0] ADDR_VALLEY    = 8'h1c;
   localparam logic [7:0] ADDR_SETPT     = 8'h20;
   localparam logic [7:0] ADDR_LASER     = 8'h24;
   localparam logic [7:0] ADDR_ERRMAP    = 8'h28;
   localparam logic [7:0] ADDR_CYCLES    = 8'h2c;
   // ctrl field positions
   localparam int CTRL_DIAG_EN   = 0;
   localparam int CTRL_ALARM_EN  = 1;
   localparam int CTRL_FAULT_LST = 2;
   localparam int CTRL_PARAM_OK  = 3;
   localparam int CTRL_MOD_FAULT = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
   // input image byte offsets
   localparam int IN_TEMP_TWO   = 0;
   localparam int IN_TEMP_WIDE  = 4;
   localparam int IN_TEMP_NAR   = 8;
   localparam int IN_TEMP_INT   = 12;
   localparam int IN_ERRMAP     = 16;
   localparam int IN_TRIGGER    = 20;
   localparam int IN_ATTEN      = 21;
   localparam int IN_BYTES      = 23;
   // output image layout
   localparam int OUT_TYPE      = 0;
   localparam int OUT_VALUE     = 1;
   localparam int OUT_BYTES     = 5;
   // parameter type codes
   localparam logic [7:0] TYPE_NONE   = 8'h00;
   localparam logic [7:0] TYPE_SLOPE  = 8'h01;
   localparam logic [7:0] TYPE_LASER  = 8'h08;
   // error bitmap bit positions
   localparam int ERR_ALARM     = 15;
   localparam int ERR_BUS_NRDY  = 17;
   localparam int ERR_USED_BITS = 19;
   // provider status qualifier values
   localparam logic [7:0] IOPS_GOOD = 8'h80;
   localparam logic [7:0] IOPS_BAD  = 8'h00;
   // update period
   localparam int CLOCK_MHZ      = 250;
   localparam int UPDATE_US      = 1000;
   localparam int UPDATE_CYCLES  = UPDATE_US * CLOCK_MHZ;
   localparam int NUM_SETTINGS   = 8;

   typedef struct packed {
      logic [31:0] temp_two;
      logic [31:0] temp_wide;
      logic [31:0] temp_narrow;
      logic [31:0] temp_internal;
      logic [31:0] err_map;
      logic        trigger;
      logic [15:0] atten;
   } meas_t;

   typedef struct packed {
      logic       frame_valid;
      logic       problem;
      logic       diag_alarm;
      logic       proc_alarm;
      logic [7:0] iops;
   } frame_status_t;
endpackage : fieldbus_image_pkg

/* File: verilog/fieldbus_process_image.sv */
// cyclic fieldbus process image: input packing, output record decode, alarms
// How it works
// - images are exchanged once every 1 ms update period.
// - two-colour, wide and narrow temperatures sit at input bytes 0, 4, 8.
// - floats go most significant byte first; housing temperature at byte 12.
// - error bitmap at byte 16; trigger state in bit 0 of byte 20.
// - attenuation is a signed 16-bit value, high byte first, at byte 21.
// - output byte 0 is the type code, bytes 1 to 4 the value.
// - codes 1 to 7 update float settings, code 8 the laser word.
// - type code zero leaves every setting untouched.
// - output records apply only during data exchange.
// - bitmap bits 0 to 8 carry heater, detector, energy and attenuation faults.
// - bits 9 to 18 carry range faults, alarm, video, bus and heater readiness.
// - diagnostics are forwarded only when the diagnostics enable is set.
// - the process alarm is forwarded only when its enable is set.
// - on module fault process data becomes zero or the last valid value.
// - an error sets the problem indicator and, with the diagnostics enable set, a diagnostic alarm.
// - each frame carries a provider status byte, good or bad.
// - cyclic data is offered only once parameters are complete.
// - slot 0 holds no process data; slot 1 carries it.
`timescale 1ns/1ns
`default_nettype none
module fieldbus_process_image (
   // clock and reset
   input  wire  logic                                 clock,
   input  wire  logic                                 rst,
   // apb slave
   input  wire  logic                                 psel,
   input  wire  logic                                 penable,
   input  wire  logic                                 pwrite,
   input  wire  logic [7:0]                           paddr,
   input  wire  logic [31:0]                          pwdata,
   output logic                                       pready,
   output logic [31:0]                                prdata,
   output logic                                       pslverr,
   // measurement side
   input  wire  fieldbus_image_pkg::meas_t            meas,
   // fieldbus side
   input  wire  logic                                 data_exchange,
   input  wire  logic [8*fieldbus_image_pkg::OUT_BYTES-1:0] out_image,
   input  wire  logic [1:0]                           frame_slot,
   output logic [8*fieldbus_image_pkg::IN_BYTES-1:0]  in_image,
   output fieldbus_image_pkg::frame_status_t          frame_status,
   output logic                                       update_strobe
);
   localparam int W = 8 * fieldbus_image_pkg::IN_BYTES;

   // big-endian byte order of a word
   function automatic logic [31:0] be32(input logic [31:0] v);
      be32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction : be32

   function automatic logic [W-1:0] pack_image(input fieldbus_image_pkg::meas_t m);
      logic [W-1:0] img;
      img = '0;
      // byte 0 sits in the low lane of the image vector
      img[8*fieldbus_image_pkg::IN_TEMP_TWO  +: 32] = be32(m.temp_two);
      img[8*fieldbus_image_pkg::IN_TEMP_WIDE +: 32] = be32(m.temp_wide);
      img[8*fieldbus_image_pkg::IN_TEMP_NAR  +: 32] = be32(m.temp_narrow);
      img[8*fieldbus_image_pkg::IN_TEMP_INT  +: 32] = be32(m.temp_internal);
      img[8*fieldbus_image_pkg::IN_ERRMAP    +: 32] = be32(m.err_map);
      img[8*fieldbus_image_pkg::IN_TRIGGER]         = m.trigger;
      img[8*fieldbus_image_pkg::IN_ATTEN     +: 16] = {m.atten[7:0], m.atten[15:8]};
      pack_image = img;
   endfunction : pack_image

   // registers
   logic [31:0]  ctrl_q;
   logic [31:0]  setting_q [fieldbus_image_pkg::NUM_SETTINGS];
   logic [31:0]  cycles_q;
   logic [17:0]  tick_q;
   logic [W-1:0] in_image_q;
   fieldbus_image_pkg::frame_status_t status_q;
   logic         update_q;
   logic         pready_q;
   logic [31:0]  prdata_q;
   logic         pslverr_q;

   // decode
   wire        tick_end   = (tick_q == 18'(fieldbus_image_pkg::UPDATE_CYCLES - 1));
   wire [7:0]  out_type   = out_image[8*fieldbus_image_pkg::OUT_TYPE +: 8];
   wire [31:0] out_value  = be32(out_image[8*fieldbus_image_pkg::OUT_VALUE +: 32]);
   wire        params_ok  = ctrl_q[fieldbus_image_pkg::CTRL_PARAM_OK];
   wire        mod_fault  = ctrl_q[fieldbus_image_pkg::CTRL_MOD_FAULT];
   wire        diag_en    = ctrl_q[fieldbus_image_pkg::CTRL_DIAG_EN];
   wire        alarm_en   = ctrl_q[fieldbus_image_pkg::CTRL_ALARM_EN];
   wire        keep_last  = ctrl_q[fieldbus_image_pkg::CTRL_FAULT_LST];
   wire        slot_one   = (frame_slot == 2'd1);
   wire        exch_ok    = data_exchange && params_ok;
   wire        type_ok    = (out_type != fieldbus_image_pkg::TYPE_NONE) &&
                            (out_type <= fieldbus_image_pkg::TYPE_LASER);
   wire        apply_rec  = tick_end && exch_ok && slot_one && type_ok;
   wire [2:0]  rec_index  = 3'(out_type - fieldbus_image_pkg::TYPE_SLOPE);
   wire [31:0] rec_value  = (out_type == fieldbus_image_pkg::TYPE_LASER) ?
                            {16'h0000, out_value[31:16]} : out_value;
   wire [31:0] err_used   = meas.err_map & 32'((64'h1 << fieldbus_image_pkg::ERR_USED_BITS) - 1);
   wire        any_error  = (err_used != 32'h0000_0000);
   wire        alarm_bit  = err_used[fieldbus_image_pkg::ERR_ALARM];
   wire        bad_data   = mod_fault || any_error;
   wire [W-1:0] fresh     = pack_image(meas);
   wire [W-1:0] substitute = keep_last ? in_image_q : '0;
   wire [W-1:0] next_image = mod_fault ? substitute : fresh;

   // apb decode
   wire        acc        = psel && penable && pready_q;
   wire        wr         = acc && pwrite;
   wire        in_setting = (paddr >= fieldbus_image_pkg::ADDR_SLOPE) &&
                            (paddr <= fieldbus_image_pkg::ADDR_LASER);
   wire [2:0]  set_index  = 3'((paddr - fieldbus_image_pkg::ADDR_SLOPE) >> 2);
   wire        mapped     = (paddr[1:0] == 2'b00) &&
                            (paddr <= fieldbus_image_pkg::ADDR_CYCLES);
   wire [31:0] status_word = {24'h0, 4'h0, bad_data, exch_ok, data_exchange, params_ok};
   wire [31:0] rd_mux =
      (paddr == fieldbus_image_pkg::ADDR_CTRL)   ? ctrl_q :
      (paddr == fieldbus_image_pkg::ADDR_STATUS) ? status_word :
      (paddr == fieldbus_image_pkg::ADDR_ERRMAP) ? err_used :
      (paddr == fieldbus_image_pkg::ADDR_CYCLES) ? cycles_q :
      in_setting                                 ? setting_q[set_index] : 32'h0000_0000;

   // update period timer: one image per 1 ms
   always_ff @(posedge clock) begin
      if (rst || tick_end) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_q + 18'd1;
      end
   end

   // control register
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_q <= fieldbus_image_pkg::CTRL_RESET;
      end else if (wr && paddr == fieldbus_image_pkg::ADDR_CTRL) begin
         ctrl_q <= {27'h0, pwdata[4:0]};
      end
   end

   // settings: software write during configuration, record during exchange
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < fieldbus_image_pkg::NUM_SETTINGS; i++) begin
            setting_q[i] <= 32'h0000_0000;
         end
      end else if (apply_rec) begin
         setting_q[rec_index] <= rec_value;
      end else if (wr && in_setting && !data_exchange) begin
         setting_q[set_index] <= pwdata;
      end
   end

   // input image and frame status, refreshed each period
   always_ff @(posedge clock) begin
      if (rst) begin
         in_image_q <= '0;
         status_q   <= '0;
         update_q   <= 1'b0;
         cycles_q   <= 32'h0000_0000;
      end else begin
         update_q <= tick_end && exch_ok && slot_one;
         if (tick_end && exch_ok && slot_one) begin
            in_image_q <= next_image;
            cycles_q   <= cycles_q + 32'd1;
            status_q.frame_valid <= 1'b1;
            status_q.problem     <= any_error;
            status_q.diag_alarm  <= any_error && diag_en;
            status_q.proc_alarm  <= alarm_bit && alarm_en;
            status_q.iops        <= bad_data ? fieldbus_image_pkg::IOPS_BAD
                                             : fieldbus_image_pkg::IOPS_GOOD;
         end else if (!exch_ok) begin
            status_q <= '0;
         end
      end
   end

   // apb slave, no wait states
   always_ff @(posedge clock) begin
      if (rst) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= psel && !penable;
         prdata_q  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
         pslverr_q <= psel && !penable && !mapped;
      end
   end

   assign pready        = pready_q;
   assign prdata        = prdata_q;
   assign pslverr       = pslverr_q;
   assign in_image      = in_image_q;
   assign frame_status  = status_q;
   assign update_strobe = update_q;

   // checks
   a_zero_type_hold: assert property (@(posedge clock) disable iff (rst)
      (tick_end && out_type == 8'h00 && !(wr && in_setting)) |=> $stable(setting_q[0]))
      else $error("setting changed on type zero");
   a_high_type_hold: assert property (@(posedge clock) disable iff (rst)
      (tick_end && out_type > 8'h08 && !(wr && in_setting)) |=> $stable(setting_q[7]))
      else $error("setting changed on unsupported type");
   a_exchange_only: assert property (@(posedge clock) disable iff (rst)
      (!data_exchange && !wr) |=> $stable(setting_q[1]))
      else $error("record applied outside exchange");
   a_record_apply: assert property (@(posedge clock) disable iff (rst)
      (apply_rec && out_type == 8'h02) |=> setting_q[1] == $past(out_value))
      else $error("emissivity record not applied");
   a_trigger_bit: assert property (@(posedge clock) disable iff (rst)
      (tick_end && exch_ok && slot_one && !mod_fault) |=> in_image[160] == $past(meas.trigger))
      else $error("trigger bit misplaced");
   a_temp_msb_first: assert property (@(posedge clock) disable iff (rst)
      (tick_end && exch_ok && slot_one && !mod_fault) |=> in_image[7:0] == $past(meas.temp_two[31:24]))
      else $error("float not big endian");
   a_fault_zero: assert property (@(posedge clock) disable iff (rst)
      (tick_end && exch_ok && slot_one && mod_fault && !keep_last) |=> in_image == '0)
      else $error("fault substitution not zero");
   a_diag_gate: assert property (@(posedge clock) disable iff (rst)
      frame_status.diag_alarm |-> frame_status.problem)
      else $error("diagnostic alarm without problem");
   a_slope_apply: assert property (@(posedge clock) disable iff (rst)
      (apply_rec && out_type == 8'h01) |=> setting_q[0] == $past(out_value))
      else $error("slope record not applied");
   a_laser_word: assert property (@(posedge clock) disable iff (rst)
      (apply_rec && out_type == 8'h08) |=> setting_q[7] == {16'h0000, $past(out_value[31:16])})
      else $error("laser word not applied");
   a_iops_match: assert property (@(posedge clock) disable iff (rst)
      update_strobe |-> ((frame_status.iops == fieldbus_image_pkg::IOPS_BAD) == $past(bad_data)))
      else $error("provider status does not match data quality");
   a_update_pulse: assert property (@(posedge clock) disable iff (rst)
      update_strobe |=> !update_strobe)
      else $error("update strobe longer than one cycle");
   a_slot_zero: assert property (@(posedge clock) disable iff (rst)
      (tick_end && !slot_one) |=> !update_strobe)
      else $error("image updated outside slot one");
   a_not_ready: assert property (@(posedge clock) disable iff (rst)
      !params_ok |=> ##1 !frame_status.frame_valid)
      else $error("frame valid before parameters");
endmodule : fieldbus_process_image
`default_nettype wire

/* File: verification/plc_model.sv */
// controller model: drives the exchange state and the output record
`timescale 1ns/1ns
`default_nettype none
module plc_model (
   // clock
   input  wire  logic                                         clock,
   // record request from the bench
   input  wire  logic                                         exchange,
   input  wire  logic [7:0]                                   rec_type,
   input  wire  logic [31:0]                                  rec_value,
   // fieldbus side
   output logic                                               data_exchange,
   output logic [8*fieldbus_image_pkg::OUT_BYTES-1:0]         out_image,
   output logic [1:0]                                         frame_slot
);
   initial data_exchange = 1'b0;
   initial out_image = '0;
   initial frame_slot = 2'h0;
   // type code rests at zero unless the bench asks for a change
   always @(posedge clock) begin
      data_exchange <= exchange;
      // process data lives in slot 1 only, slot 0 is addressed while idle
      frame_slot <= exchange ? 2'h1 : 2'h0;
      // value high byte sits in byte 1, right after the type byte
      out_image <= {rec_value[7:0], rec_value[15:8], rec_value[23:16], rec_value[31:24], rec_type};
   end
endmodule : plc_model
`default_nettype wire

/* File: verification/test_fieldbus_process_image.sv */
// self-checking bench for the fieldbus process image block
`timescale 1ns/1ns
`default_nettype none
module test_fieldbus_process_image;
   logic                              clock, rst, psel, penable, pwrite, pready, pslverr, exchange;
   logic                              data_exchange, update_strobe, err;
   logic [7:0]                        paddr, rec_type;
   logic [31:0]                       pwdata, prdata, rec_value, rd, seed, slope_exp;
   logic [1:0]                        frame_slot;
   logic [39:0]                       out_image;
   logic [183:0]                      in_image, img_exp;
   fieldbus_image_pkg::meas_t         meas;
   fieldbus_image_pkg::frame_status_t frame_status;
   int                                failures, comparisons, cyc, last_cyc;

   fieldbus_process_image i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .meas(meas),
      .data_exchange(data_exchange), .out_image(out_image), .frame_slot(frame_slot), .in_image(in_image),
      .frame_status(frame_status), .update_strobe(update_strobe));
   plc_model i_plc (.clock(clock), .exchange(exchange), .rec_type(rec_type), .rec_value(rec_value),
      .data_exchange(data_exchange), .out_image(out_image), .frame_slot(frame_slot));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) cyc <= cyc + 1;

   task fail(input string msg);
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask : fail
   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
   endtask : chk_word
   task chk_image(input logic [183:0] got, input logic [183:0] exp);
      comparisons++;
      if (got !== exp) fail("input image mismatch");
   endtask : chk_image
   task chk_status(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) fail($sformatf("frame status %h expected %h", got, exp));
   endtask : chk_status
   task wrap_up;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   // request held from setup until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail("apb answer timed out");
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   // bench model of the image: every field big endian, byte k at bits 8k+7..8k
   function automatic logic [183:0] exp_img(input fieldbus_image_pkg::meas_t m);
      logic [183:0] b, v;
      b = {m.temp_two, m.temp_wide, m.temp_narrow, m.temp_internal, m.err_map, 7'h00, m.trigger, m.atten};
      for (int k = 0; k < 23; k++) v[8*k +: 8] = b[183-8*k -: 8];
      return v;
   endfunction : exp_img

   task period(input logic [7:0] t, input logic [31:0] ctrl);
      logic [31:0] v, r;
      logic        p;
      int          n;
      v = $random(seed);
      r = $random(seed);
      rec_type <= t; rec_value <= v;
      // errors only when diagnostics are on, so the clean frame with a good qualifier is seen too
      meas <= {$random(seed), $random(seed), $random(seed), $random(seed),
               ctrl[0] ? ((r & 32'h0007_ffff) | 32'h0000_8000) : 32'h0000_0000, r[16:0]};
      apb(1'b1, fieldbus_image_pkg::ADDR_CTRL, ctrl);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (update_strobe !== 1'b1 && n < 300000);
      if (n >= 300000) begin
         fail("no image update");
         wrap_up();
      end
      if (last_cyc != 0) chk_word(cyc - last_cyc, fieldbus_image_pkg::UPDATE_CYCLES);
      last_cyc = cyc;
      p = |meas.err_map[18:0];
      if (ctrl[4]) begin
         // keep-last fault: image must not move and the data is flagged bad
         chk_image(in_image, img_exp);
         chk_word({24'h0, frame_status.iops}, {24'h0, fieldbus_image_pkg::IOPS_BAD});
      end else begin
         img_exp = exp_img(meas);
         chk_image(in_image, img_exp);
         chk_status(frame_status, {1'b1, p, p & ctrl[0], ctrl[1] & meas.err_map[15],
            p ? fieldbus_image_pkg::IOPS_BAD : fieldbus_image_pkg::IOPS_GOOD});
         if (t == 8'h01) slope_exp = v;
      end
      apb(1'b0, fieldbus_image_pkg::ADDR_SLOPE, 32'h0);
      chk_word(rd, slope_exp);
      apb(1'b0, fieldbus_image_pkg::ADDR_LASER, 32'h0);
      if (t == 8'h08) chk_word({16'h0, rd[15:0]}, {16'h0, v[31:16]});
      $display("test period type %0d done", t);
   endtask : period

   initial begin
      seed = 32'hd590;
      failures = 0; comparisons = 0; cyc = 0; last_cyc = 0;
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      exchange = 1'b0; rec_type = 8'h00; rec_value = 32'h0; meas = '0; img_exp = '0; slope_exp = 32'h0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, fieldbus_image_pkg::ADDR_CTRL, 32'h0);
      chk_word(rd, fieldbus_image_pkg::CTRL_RESET);
      apb(1'b0, 8'h40, 32'h0);
      chk_word({rd[30:0], err}, 32'h1);
      apb(1'b1, fieldbus_image_pkg::ADDR_EMIS, 32'h0000_0384);
      exchange <= 1'b1;
      repeat (3) @(posedge clock);
      // software setting writes are refused during data exchange
      apb(1'b1, fieldbus_image_pkg::ADDR_EMIS, 32'h0000_0100);
      apb(1'b0, fieldbus_image_pkg::ADDR_EMIS, 32'h0);
      chk_word(rd, 32'h0000_0384);
      $display("test register access done");
      period(8'h01, 32'h0000_000b);
      period(8'h08, 32'h0000_0008);
      period(8'h09, 32'h0000_001f);
      wrap_up();
   end
endmodule : test_fieldbus_process_image
`default_nettype wire
